// File: sim/cml_counter_tb.sv
/*
 * cml_counter_tb: APB register tests of one counter in modes A B Q V X S.
 * Assumes an APB slave that raises pready in time, pin edges seen late.
 */
`timescale 1ns/100ps
`default_nettype none
module cml_counter_tb
    import cml_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tc_out;
    wire logic gate_pin;
    wire logic source_pin;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int tcs = 0;
    logic [31:0] q;
    logic s;

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    err_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end

    cml_counter uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gate_pin(gate_pin),
        .source_pin(source_pin), .tc_out(tc_out));
    cml_far_model far (.pclk(pclk), .gate_pin(gate_pin),
        .source_pin(source_pin));

    // 10 MHz clock
    always #50 pclk = ~pclk;

    // terminal pulses and hang guard
    always @(posedge pclk) begin
        cyc++;
        if (tc_out === 1'b1)
            tcs++;
        if (cyc > 5000) begin
            err_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        s = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic ck(input logic [11:0] a, input logic [31:0] e,
                      input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, q)
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and unmapped place
        ck(CML_OFF_MODE, 32'h00000800, "mode rst");
        ck(CML_OFF_STAT, 32'h00000000, "stat rst");
        apb(1'b0, 12'h018, 32'h0);
        `CHK("slverr", 1'b1, s)
        apb(1'b1, 12'h01C, 32'h0);
        `CHK("wr slverr", 1'b1, s)
        $display("test reset done");
        // mode A; gate high must not matter; mode writes ignored while armed
        far.gate(1'b1);
        apb(1'b1, CML_OFF_MODE, 32'h00000000);
        apb(1'b1, CML_OFF_LOAD, 32'h00000003);
        apb(1'b1, CML_OFF_CMD, 32'h00000004);
        apb(1'b1, CML_OFF_CMD, 32'h00000001);
        ck(CML_OFF_COUNT, 32'h00000003, "a load");
        apb(1'b1, CML_OFF_MODE, 32'h00008000);
        ck(CML_OFF_MODE, 32'h00000000, "armed mode wr");
        far.src(2);
        ck(CML_OFF_COUNT, 32'h00000001, "a count");
        far.src(1);
        ck(CML_OFF_COUNT, 32'h00000003, "a reload");
        `CHK("a tc", 1, tcs)
        apb(1'b0, CML_OFF_STAT, 32'h0);
        `CHK("a tc armed", 1'b1, q[0])
        far.src(1);
        apb(1'b0, CML_OFF_STAT, 32'h0);
        `CHK("a disarm", 1'b0, q[0])
        far.src(1);
        ck(CML_OFF_COUNT, 32'h00000003, "a idle");
        $display("test mode a done");
        // mode B: nothing before arm, then counts only with gate high
        apb(1'b1, CML_OFF_MODE, 32'h00008000);
        far.src(1);
        ck(CML_OFF_COUNT, 32'h00000003, "b unarmed");
        apb(1'b1, CML_OFF_CMD, 32'h00000001);
        far.src(1);
        ck(CML_OFF_COUNT, 32'h00000002, "b gate hi");
        far.gate(1'b0);
        far.src(1);
        ck(CML_OFF_COUNT, 32'h00000002, "b gate lo");
        apb(1'b1, CML_OFF_CMD, 32'h00000002);
        $display("test mode b done");
        // mode Q: capture, retrigger, repeat
        apb(1'b1, CML_OFF_MODE, 32'h000080A0);
        apb(1'b1, CML_OFF_LOAD, 32'h00000005);
        apb(1'b1, CML_OFF_CMD, 32'h00000004);
        apb(1'b1, CML_OFF_CMD, 32'h00000001);
        apb(1'b1, CML_OFF_LOAD, 32'h00000009);
        far.gate(1'b1);
        ck(CML_OFF_HOLD, 32'h00000005, "q hold");
        far.src(1);
        ck(CML_OFF_COUNT, 32'h00000009, "q first");
        far.src(1);
        ck(CML_OFF_COUNT, 32'h00000008, "q second");
        far.src(9);
        ck(CML_OFF_COUNT, 32'h00000009, "q wrap");
        apb(1'b0, CML_OFF_STAT, 32'h0);
        `CHK("q armed", 1'b1, q[0])
        apb(1'b1, CML_OFF_CMD, 32'h00000002);
        $display("test mode q done");
        // mode V: gate picks hold or load at each terminal count
        apb(1'b1, CML_OFF_MODE, 32'h000000E0);
        apb(1'b1, CML_OFF_LOAD, 32'h00000002);
        apb(1'b1, CML_OFF_CMD, 32'h00000005);
        far.src(2);
        ck(CML_OFF_COUNT, 32'h00000005, "v from hold");
        far.gate(1'b0);
        far.src(5);
        ck(CML_OFF_COUNT, 32'h00000001, "v ungated");
        far.src(1);
        ck(CML_OFF_COUNT, 32'h00000002, "v from load");
        apb(1'b0, CML_OFF_STAT, 32'h0);
        `CHK("v armed", 1'b1, q[0])
        $display("test mode v done");
        // mode X: gate edge starts, later edges only sample
        apb(1'b1, CML_OFF_CMD, 32'h00000002);
        apb(1'b1, CML_OFF_MODE, 32'h000020E0);
        apb(1'b1, CML_OFF_LOAD, 32'h00000004);
        apb(1'b1, CML_OFF_CMD, 32'h00000005);
        far.src(1);
        ck(CML_OFF_COUNT, 32'h00000004, "x waits edge");
        far.gate(1'b1);
        far.src(1);
        ck(CML_OFF_COUNT, 32'h00000003, "x started");
        far.gate(1'b0);
        far.gate(1'b1);
        ck(CML_OFF_HOLD, 32'h00000003, "x sample");
        ck(CML_OFF_COUNT, 32'h00000003, "x no reload");
        far.src(4);
        ck(CML_OFF_COUNT, 32'h00000004, "x tc reload");
        far.src(1);
        ck(CML_OFF_COUNT, 32'h00000004, "x stopped");
        $display("test mode x done");
        // mode S: gate high reloads hold, disarms after second terminal
        apb(1'b1, CML_OFF_CMD, 32'h00000002);
        apb(1'b1, CML_OFF_MODE, 32'h000000C0);
        apb(1'b1, CML_OFF_LOAD, 32'h00000002);
        apb(1'b1, CML_OFF_CMD, 32'h00000005);
        far.src(3);
        ck(CML_OFF_COUNT, 32'h00000003, "s from hold");
        apb(1'b0, CML_OFF_STAT, 32'h0);
        `CHK("s first tc", 1'b1, q[0])
        far.src(4);
        apb(1'b0, CML_OFF_STAT, 32'h0);
        `CHK("s second tc", 1'b0, q[0])
        `CHK("tc pulses", 7, tcs)
        $display("test mode s done");
        final_report();
    end
endmodule // cml_counter_tb
`default_nettype wire

// File: sim/cml_far_model.sv
/*
 * cml_far_model: drives the gate and counting-source pins of one counter.
 * Assumes the design passes each pin through a 3-4 cycle synchroniser.
 */
`timescale 1ns/100ps
`default_nettype none
module cml_far_model (
    input wire logic pclk,
    output logic gate_pin,
    output logic source_pin
);
    // pins idle low at time zero
    initial begin
        gate_pin = 1'b0;
        source_pin = 1'b0;
    end

    // wide pulses so every edge clears the synchroniser before the next
    // rising edge counts once
    task automatic src(input int n);
        repeat (n) begin
            @(posedge pclk);
            source_pin <= 1'b1;
            repeat (6) @(posedge pclk);
            source_pin <= 1'b0;
            repeat (6) @(posedge pclk);
        end
    endtask

    // gate level change, then settle past the synchroniser
    task automatic gate(input logic v);
        @(posedge pclk);
        gate_pin <= v;
        repeat (8) @(posedge pclk);
    endtask
endmodule // cml_far_model
`default_nettype wire

// File: verilog/cml_counter.sv
/*
 * cml_counter: one general counter with mode selection, arm/load commands,
 * gate handling and hold capture, reached over APB.
 * Assumes gate and source are asynchronous pins, active high, and source
 * edges are well below pclk/4. Counts down, binary.
 */
`timescale 1ns/100ps
`default_nettype none
// Function
// - mode from gate field and three bits
// - repeat bit clear disarms, set repeats
// - only rising source and gate edges count
// - terminal count always advances next edge
// - mode A counts all edges, gate ignored
// - mode A reloads at terminal, disarms on the next edge
// - mode B counts only while gate active
// - mode B waits arm, reloads, disarms
// - modes N O count once then disarm
// - modes O R X start on gate edge
// - modes N O Q R capture and retrigger
// - modes Q R repeat reloading from load
// - modes S V reload by gate level
// - S counts twice, V repeats, ungated
// - S V gate selects reload only
// - mode X gate captures without reload
// - mode X kept on this revision
// - retrigger: first edge loads, second counts
module cml_counter
    import cml_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic gate_pin,
    input wire logic source_pin,
    output logic tc_out
);
    cml_state_t st_r;
    cml_state_t st_nxt;
    logic tc_r;
    logic tc_nxt;
    logic pready_r;
    logic pslverr_r;
    logic pslverr_nxt;
    logic gate_lvl;
    logic gate_rise;
    logic src_rise;
    logic [2:0] gc;
    logic spg;
    logic rld;
    logic rep;
    logic lvl_gate;
    logic edge_gate;
    logic retrig;
    logic sample_x;
    logic qual;
    logic wr;
    logic rd;
    logic [15:0] cmdw;

    cml_sync u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .pin(gate_pin),
        .level(gate_lvl),
        .rise(gate_rise)
    );

    cml_sync u_src (
        .pclk(pclk),
        .presetn(presetn),
        .pin(source_pin),
        .level(),
        .rise(src_rise)
    );

    // decode from the mode bits only
    assign gc = st_r.mode[CML_GC_MSB:CML_GC_LSB];
    assign spg = st_r.mode[CML_SPG_BIT];
    assign rld = st_r.mode[CML_RLD_BIT];
    assign rep = st_r.mode[CML_REP_BIT];
    // reserved encodings behave as their neighbours
    assign lvl_gate = (gc == CML_GC_LEVEL);
    assign edge_gate = (gc != CML_GC_NONE) && !lvl_gate;
    assign retrig = spg && !rld && (gc != CML_GC_NONE);
    // mode X samples on gate edge
    assign sample_x = spg && rld && rep && edge_gate;
    // level qualification; S V never gated
    assign qual = !lvl_gate || gate_lvl || (spg && rld);

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign cmdw = pwdata[15:0];

    // main sequencing, one step per qualified source edge
    always_comb begin
        st_nxt = st_r;
        tc_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        // gate edge handling, ignored while disarmed
        if (gate_rise && st_r.armed) begin
            if (retrig) begin
                st_nxt.hold = st_r.count;
                st_nxt.pend = 1'b1;
                st_nxt.run = 1'b1;
            end else if (sample_x && st_r.run) begin
                st_nxt.hold = st_r.count;
            end else if (edge_gate) begin
                st_nxt.run = 1'b1;
            end
        end
        if (src_rise) begin
            if (st_r.at_tc) begin
                // leaving terminal count regardless of gating
                // stop and disarm wait for this edge, not the one before
                st_nxt.at_tc = 1'b0;
                if (spg && rld && !edge_gate && !rep) begin
                    // mode S disarms after second terminal
                    st_nxt.second = ~st_r.second;
                    st_nxt.armed = st_r.second ? 1'b0 : st_r.armed;
                end else if (!rep) begin
                    st_nxt.armed = 1'b0;
                end
                // edge modes stop until next edge
                if (edge_gate) begin
                    st_nxt.run = 1'b0;
                end
            end else if (st_r.armed && st_r.run && qual && st_r.pend) begin
                st_nxt.count = st_r.load;
                st_nxt.pend = 1'b0;
            end else if (st_r.armed && st_r.run && qual) begin
                if (st_r.count == CML_TC_VAL) begin
                    tc_nxt = 1'b1;
                    st_nxt.at_tc = 1'b1;
                    // reload source chosen by gate level
                    if (spg && rld && !edge_gate && gate_lvl) begin
                        st_nxt.count = st_r.hold;
                    end else begin
                        st_nxt.count = st_r.load;
                    end
                    // stop and disarm are left to the edge leaving terminal
                end else begin
                    st_nxt.count = st_r.count - CML_TC_VAL;
                end
            end
        end
        // register writes take effect at the access phase
        if (wr) begin
            unique case (paddr)
                CML_OFF_MODE: begin
                    // ignored while armed, to avoid erratic runs
                    if (!st_r.armed) begin
                        st_nxt.mode = cmdw;
                    end
                end
                CML_OFF_LOAD: st_nxt.load = cmdw;
                CML_OFF_CMD: begin
                    if (cmdw[CML_CMD_LOAD]) begin
                        st_nxt.count = st_r.load;
                    end
                    if (cmdw[CML_CMD_ARM]) begin
                        st_nxt.armed = 1'b1;
                        st_nxt.run = !edge_gate;
                        st_nxt.second = 1'b0;
                        st_nxt.pend = 1'b0;
                    end
                    if (cmdw[CML_CMD_DISARM]) begin
                        st_nxt.armed = 1'b0;
                    end
                end
                CML_OFF_HOLD, CML_OFF_STAT, CML_OFF_COUNT: begin
                end
                // unmapped: no effect, the error was raised in setup
                default: begin
                end
            endcase
        end
        // read data captured in setup, shown in access
        if (rd) begin
            unique case (paddr)
                CML_OFF_MODE: st_nxt.prdata = {CML_ZERO16, st_r.mode};
                CML_OFF_LOAD: st_nxt.prdata = {CML_ZERO16, st_r.load};
                CML_OFF_HOLD: st_nxt.prdata = {CML_ZERO16, st_r.hold};
                CML_OFF_STAT: st_nxt.prdata = {28'h0000000, st_r.at_tc,
                    st_r.pend, st_r.run, st_r.armed};
                CML_OFF_COUNT: st_nxt.prdata = {CML_ZERO16, st_r.count};
                default: st_nxt.prdata = 32'h00000000;
            endcase
        end
        // unmapped address flagged in setup, reads and writes alike
        if (psel && !penable) begin
            case (paddr)
                CML_OFF_MODE, CML_OFF_LOAD, CML_OFF_HOLD, CML_OFF_STAT,
                CML_OFF_COUNT, CML_OFF_CMD: begin
                end
                default: pslverr_nxt = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.mode <= CML_MODE_RST;
            tc_r <= 1'b0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            tc_r <= tc_nxt;
            pready_r <= psel && !penable;
            pslverr_r <= psel && !penable && pslverr_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign tc_out = tc_r;

    // a terminal count is left on the very next source edge
    a_tc_leaves: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.at_tc && src_rise |=> !st_r.at_tc)
        else $error("counter stayed at terminal count");
    a_once_disarm: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.at_tc && src_rise && !rep && !(spg && rld) && !wr
        |=> !st_r.armed)
        else $error("count-once mode still armed after terminal");
    a_rep_armed: assert property (@(posedge pclk) disable iff (!presetn)
        tc_r && rep && !$past(wr) |-> st_r.armed)
        else $error("repeating mode disarmed itself");
    a_no_count_disarm: assert property (@(posedge pclk) disable iff (!presetn)
        !st_r.armed && !st_r.at_tc && !wr |=> $stable(st_r.count))
        else $error("disarmed counter changed its count");
    a_level_gate: assert property (@(posedge pclk) disable iff (!presetn)
        lvl_gate && !(spg && rld) && !gate_lvl && !st_r.at_tc && !wr
        |=> $stable(st_r.count))
        else $error("counted with gate inactive");
    a_retrig_hold: assert property (@(posedge pclk) disable iff (!presetn)
        gate_rise && st_r.armed && retrig |=> st_r.hold == $past(st_r.count)
        && st_r.pend)
        else $error("retrigger did not capture count");
    a_x_sample: assert property (@(posedge pclk) disable iff (!presetn)
        gate_rise && st_r.armed && st_r.run && sample_x && !src_rise
        |=> st_r.hold == $past(st_r.count) && !st_r.pend)
        else $error("sampling mode failed to capture");
    a_mode_locked: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.armed && wr && paddr == CML_OFF_MODE |=> $stable(st_r.mode))
        else $error("mode changed while armed");
    a_pready_one: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready)
        else $error("apb answer late");
    a_tc_disarm_late: assert property (
        @(posedge pclk) disable iff (!presetn)
        tc_r && $past(st_r.armed) && !$past(wr) |-> st_r.armed)
        else $error("counter disarmed on reaching terminal count");
    a_tc_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        tc_r |=> !tc_r)
        else $error("terminal pulse longer than one cycle");
    a_edge_waits: assert property (
        @(posedge pclk) disable iff (!presetn)
        edge_gate && !st_r.run && !st_r.at_tc && !wr
        |=> $stable(st_r.count))
        else $error("edge-gated counter counted before its trigger");
    a_edge_stop: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_r.at_tc && src_rise && edge_gate && !gate_rise && !wr
        |=> !st_r.run)
        else $error("edge-gated counter kept running past terminal");
    a_hold_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        !gate_rise |=> $stable(st_r.hold))
        else $error("hold register changed without a gate edge");
    a_reload_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        spg && rld && !edge_gate && gate_lvl && src_rise && !st_r.at_tc
        && st_r.armed && st_r.run && !st_r.pend
        && st_r.count == CML_TC_VAL && !wr
        |=> st_r.count == $past(st_r.hold))
        else $error("terminal count did not reload from hold");
    a_s_first: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_r.at_tc && src_rise && spg && rld && !edge_gate && !rep
        && !st_r.second && !wr
        |=> st_r.second && st_r.armed == $past(st_r.armed))
        else $error("twice mode disarmed after its first terminal");
    a_sv_ungated: assert property (
        @(posedge pclk) disable iff (!presetn)
        spg && rld && src_rise && !st_r.at_tc && st_r.armed && st_r.run
        && !st_r.pend && st_r.count != CML_TC_VAL && !wr
        |=> st_r.count == $past(st_r.count) - CML_TC_VAL)
        else $error("gate stopped counting in a reload-select mode");
    a_x_no_reload: assert property (
        @(posedge pclk) disable iff (!presetn)
        gate_rise && st_r.armed && st_r.run && sample_x && !src_rise && !wr
        |=> st_r.count == $past(st_r.count) && st_r.run)
        else $error("sampling gate edge disturbed the count");
    a_pend_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        src_rise && !st_r.at_tc && st_r.pend && st_r.armed && st_r.run
        && qual && !gate_rise && !wr
        |=> st_r.count == $past(st_r.load) && !st_r.pend)
        else $error("retrigger did not load on first source edge");
    a_arm_cmd: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == CML_OFF_CMD && cmdw[CML_CMD_ARM]
        && !cmdw[CML_CMD_DISARM] |=> st_r.armed && !st_r.pend)
        else $error("arm command did not arm the counter");
    a_disarm_cmd: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == CML_OFF_CMD && cmdw[CML_CMD_DISARM] |=> !st_r.armed)
        else $error("disarm command did not disarm the counter");
    a_load_cmd: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == CML_OFF_CMD && cmdw[CML_CMD_LOAD]
        |=> st_r.count == $past(st_r.load))
        else $error("load command did not copy the load register");

    c_tc_seen: cover property (@(posedge pclk) tc_r);
    c_retrig: cover property (@(posedge pclk) gate_rise && retrig && st_r.armed);
    c_sample: cover property (@(posedge pclk) gate_rise && sample_x && st_r.run);
    c_second: cover property (@(posedge pclk) tc_r && st_r.second);
    c_s_disarm: cover property (@(posedge pclk) st_r.at_tc && src_rise
        && st_r.second);
endmodule // cml_counter
`default_nettype wire

// File: verilog/cml_pkg.sv
/*
 * cml_pkg: constants and types for the counter operating mode logic.
 * Assumes a single pclk domain; register map is an APB slave, 32-bit data.
 */
package cml_pkg;
    // register byte offsets
    localparam logic [11:0] CML_OFF_MODE = 12'h000;
    localparam logic [11:0] CML_OFF_LOAD = 12'h004;
    localparam logic [11:0] CML_OFF_HOLD = 12'h008;
    localparam logic [11:0] CML_OFF_CMD = 12'h00C;
    localparam logic [11:0] CML_OFF_STAT = 12'h010;
    localparam logic [11:0] CML_OFF_COUNT = 12'h014;
    // mode register field positions
    localparam int CML_REP_BIT = 5;
    localparam int CML_RLD_BIT = 6;
    localparam int CML_SPG_BIT = 7;
    localparam int CML_GC_LSB = 13;
    localparam int CML_GC_MSB = 15;
    // mode register reset value: count once, no gating
    localparam logic [15:0] CML_MODE_RST = 16'h0800;
    // command register bits
    localparam int CML_CMD_ARM = 0;
    localparam int CML_CMD_DISARM = 1;
    localparam int CML_CMD_LOAD = 2;
    // gate control encodings: 000 none, 100 level, others edge
    localparam logic [2:0] CML_GC_NONE = 3'h0;
    localparam logic [2:0] CML_GC_LEVEL = 3'h4;
    localparam logic [15:0] CML_TC_VAL = 16'h0001;
    localparam logic [15:0] CML_ZERO16 = 16'h0000;

    // three-stage input synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic val;
    } cml_sync_t;

    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] load;
        logic [15:0] hold;
        logic [15:0] count;
        logic armed;
        logic run;
        logic pend;
        logic second;
        logic at_tc;
        logic [31:0] prdata;
    } cml_state_t;
endpackage : cml_pkg

// File: verilog/cml_sync.sv
/*
 * cml_sync: three-flop pin synchroniser with agreement filter and
 * rising-edge pulse. Assumes the pin is asynchronous to pclk.
 */
`timescale 1ns/100ps
`default_nettype none
module cml_sync
    import cml_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level,
    output logic rise
);
    cml_sync_t st_r;
    cml_sync_t st_nxt;
    logic rise_r;
    logic rise_nxt;

    // accept a change only when stages two and three agree
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        rise_nxt = 1'b0;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.val = st_r.s3;
            rise_nxt = st_r.s3 & ~st_r.val;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            rise_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            rise_r <= rise_nxt;
        end
    end

    assign level = st_r.val;
    assign rise = rise_r;

    a_rise_single: assert property (@(posedge pclk) disable iff (!presetn)
        rise |=> !rise) else $error("edge pulse longer than one cycle");
endmodule // cml_sync
`default_nettype wire
